//--- verilog/anps_regs.sv
`timescale 1ns/100ps
module anps_regs #(
    parameter int   DATA_W        = 16,
    parameter int   ADDR_W        = 5,
    parameter logic LOCAL_NP_ABLE = 1'h1
) (
    // clock and reset
    input  wire logic              i_clock,
    input  wire logic              i_reset,
    // management register port
    input  wire logic              i_reg_rd,
    input  wire logic              i_reg_wr,
    input  wire logic [ADDR_W-1:0] i_reg_addr,
    output logic      [DATA_W-1:0] o_reg_rdata,
    output logic                   o_reg_rvalid,
    output logic                   o_reg_wack,
    // page reception from negotiation engine
    input  wire logic              i_page_stored,
    input  wire logic              i_page_is_base,
    input  wire logic [DATA_W-1:0] i_page_word,
    // negotiation engine state
    input  wire logic              i_base_page,
    input  wire logic              i_parallel_fault,
    input  wire logic              i_partner_an_able,
    input  wire logic              i_page_received_variable,
    input  wire logic              i_transmit_disable,
    // port configuration
    input  wire logic              i_alternate_next_page_feature,
    // status towards the rest of the device
    output logic      [DATA_W-1:0] o_partner_ability,
    output logic      [DATA_W-1:0] o_partner_next_page,
    output logic                   o_page_received,
    output logic                   o_selector_ieee_8023,
    output logic                   o_selector_reserved
);

    // elaboration checks
    if (DATA_W != 16) begin : g_bad_width
        $error("anps_regs: DATA_W must be 16");
    end
    if (ADDR_W != 5) begin : g_bad_addr
        $error("anps_regs: ADDR_W must be 5");
    end

    function automatic logic sel_reserved(input logic [4:0] sel);
        sel_reserved = (sel == anps_pkg::SEL_RSVD_LOW) ||
                       (sel == anps_pkg::SEL_RSVD_HIGH) ||
                       ((sel != anps_pkg::SEL_IEEE_8023) &&
                        (sel != anps_pkg::SEL_IEEE_8029));
    endfunction : sel_reserved

    // decoded strobes
    wire logic              hit_ability;
    wire logic              hit_expansion;
    wire logic              hit_next;
    wire logic              read_expansion;
    wire logic              load_base;
    wire logic              load_next;
    wire logic              alt_clear;
    wire logic              page_rx_clear;
    wire logic              base_flag_clear;
    wire logic              pd_flag_clear;
    wire logic              base_flag_set;

    // held contents
    wire logic [DATA_W-1:0] ability_word;
    wire logic [DATA_W-1:0] next_word;
    wire logic              base_flag;
    wire logic              pd_flag;
    wire logic              page_rx_flag;
    wire logic              lp_np_able;
    logic      [DATA_W-1:0] expansion_word;
    wire logic [DATA_W-1:0] read_mux;
    wire logic [4:0]        sel_code;

    logic                   lp_an_able_r;
    logic                   lp_an_able_nxt;
    logic                   np_able_r;

    assign hit_ability    = (i_reg_addr == anps_pkg::ADDR_PARTNER_ABILITY);
    assign hit_expansion  = (i_reg_addr == anps_pkg::ADDR_EXPANSION);
    assign hit_next       = (i_reg_addr == anps_pkg::ADDR_PARTNER_NEXT);
    assign read_expansion = i_reg_rd & hit_expansion;

    // base and next pages go to separate registers
    assign load_base = i_page_stored & i_page_is_base;
    assign load_next = i_page_stored & ~i_page_is_base;

    // extra clear only under the alternate next page feature
    assign alt_clear = i_alternate_next_page_feature &
                       (~i_page_received_variable |
                        i_transmit_disable);
    assign page_rx_clear   = read_expansion | alt_clear;
    assign base_flag_clear = read_expansion;
    assign pd_flag_clear   = read_expansion;

    // base page flag tracks sync with the negotiation state diagram only under the alternate next page feature
    assign base_flag_set = i_base_page &
                           i_alternate_next_page_feature;

    // received base page, reserved bit masked to zero
    anps_word_store #(
        .WIDTH       (DATA_W),
        .RESET_VALUE (anps_pkg::ABILITY_RESET),
        .MASK        (anps_pkg::ABILITY_MASK)
    ) u_ability (
        .i_clock (i_clock),
        .i_reset (i_reset),
        .i_load  (load_base),
        .i_word  (i_page_word),
        .o_word  (ability_word)
    );

    // received next page
    anps_word_store #(
        .WIDTH       (DATA_W),
        .RESET_VALUE (anps_pkg::NEXT_RESET),
        .MASK        (anps_pkg::NEXT_MASK)
    ) u_next (
        .i_clock (i_clock),
        .i_reset (i_reset),
        .i_load  (load_next),
        .i_word  (i_page_word),
        .o_word  (next_word)
    );

    anps_latch_flag #(
        .RESET_VALUE (anps_pkg::FLAG_RESET)
    ) u_base_flag (
        .i_clock (i_clock),
        .i_reset (i_reset),
        .i_set   (base_flag_set),
        .i_clear (base_flag_clear),
        .o_flag  (base_flag)
    );

    anps_latch_flag #(
        .RESET_VALUE (anps_pkg::FLAG_RESET)
    ) u_pd_flag (
        .i_clock (i_clock),
        .i_reset (i_reset),
        .i_set   (i_parallel_fault),
        .i_clear (pd_flag_clear),
        .o_flag  (pd_flag)
    );

    // set in the same edge the word is loaded
    anps_latch_flag #(
        .RESET_VALUE (anps_pkg::FLAG_RESET)
    ) u_page_rx_flag (
        .i_clock (i_clock),
        .i_reset (i_reset),
        .i_set   (i_page_stored),
        .i_clear (page_rx_clear),
        .o_flag  (page_rx_flag)
    );

    // partner next page ability comes from its stored base page
    assign lp_np_able = ability_word[anps_pkg::ABL_NEXT_PAGE];

    assign lp_an_able_nxt = i_partner_an_able;

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            lp_an_able_r <= anps_pkg::FLAG_RESET;
        end else begin
            lp_an_able_r <= lp_an_able_nxt;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            np_able_r <= anps_pkg::NP_ABLE_RESET;
        end else begin
            np_able_r <= LOCAL_NP_ABLE;
        end
    end

    // reserved bits stay zero
    always_comb begin
        expansion_word = anps_pkg::READ_ZERO;
        expansion_word[anps_pkg::EXP_BASE_PAGE]  = base_flag;
        expansion_word[anps_pkg::EXP_PD_FAULT]   = pd_flag;
        expansion_word[anps_pkg::EXP_LP_NP_ABLE] = lp_np_able;
        expansion_word[anps_pkg::EXP_NP_ABLE]    = np_able_r;
        expansion_word[anps_pkg::EXP_PAGE_RX]    = page_rx_flag;
        expansion_word[anps_pkg::EXP_LP_AN_ABLE] = lp_an_able_r;
    end

    // unmapped addresses read zero
    assign read_mux = hit_ability   ? ability_word   :
                      hit_expansion ? expansion_word :
                      hit_next      ? next_word      :
                                      anps_pkg::READ_ZERO;

    assign sel_code = ability_word[anps_pkg::ABL_SEL_HI:anps_pkg::ABL_SEL_LO];

    // read data captured before the clear takes effect
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_reg_rdata  <= anps_pkg::READ_ZERO;
            o_reg_rvalid <= 1'h0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= read_mux;
            end
        end
    end

    // writes acknowledged unless a read comes in the same cycle, and discarded
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_reg_wack <= 1'h0;
        end else begin
            o_reg_wack <= i_reg_wr & ~i_reg_rd;
        end
    end

    // status copies for the rest of the device
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_partner_ability    <= anps_pkg::ABILITY_RESET;
            o_partner_next_page  <= anps_pkg::NEXT_RESET;
            o_page_received      <= anps_pkg::FLAG_RESET;
            o_selector_ieee_8023 <= 1'h0;
            o_selector_reserved  <= 1'h0;
        end else begin
            o_partner_ability    <= ability_word;
            o_partner_next_page  <= next_word;
            o_page_received      <= page_rx_flag;
            o_selector_ieee_8023 <= (sel_code == anps_pkg::SEL_IEEE_8023);
            o_selector_reserved  <= load_base &
                sel_reserved(i_page_word[anps_pkg::ABL_SEL_HI:
                                         anps_pkg::ABL_SEL_LO]) |
                (o_selector_reserved & ~load_base);
        end
    end

endmodule : anps_regs

//--- common/anps_pkg.sv
package anps_pkg;

    // management register addresses
    localparam logic [4:0] ADDR_PARTNER_ABILITY = 5'h05;
    localparam logic [4:0] ADDR_EXPANSION       = 5'h06;
    localparam logic [4:0] ADDR_PARTNER_NEXT    = 5'h08;

    // partner base page ability fields
    localparam int ABL_NEXT_PAGE   = 15;
    localparam int ABL_ACK         = 14;
    localparam int ABL_REM_FAULT   = 13;
    localparam int ABL_RESERVED    = 12;
    localparam int ABL_ASYM_PAUSE  = 11;
    localparam int ABL_PAUSE       = 10;
    localparam int ABL_TECH_HI     = 9;
    localparam int ABL_TECH_LO     = 5;
    localparam int ABL_SEL_HI      = 4;
    localparam int ABL_SEL_LO      = 0;

    // expansion fields
    localparam int EXP_BASE_PAGE   = 5;
    localparam int EXP_PD_FAULT    = 4;
    localparam int EXP_LP_NP_ABLE  = 3;
    localparam int EXP_NP_ABLE     = 2;
    localparam int EXP_PAGE_RX     = 1;
    localparam int EXP_LP_AN_ABLE  = 0;

    // reset values and masks
    localparam logic [15:0] ABILITY_RESET = 16'h0000;
    localparam logic [15:0] ABILITY_MASK  = 16'hEFFF;
    localparam logic [15:0] NEXT_RESET    = 16'h0000;
    localparam logic [15:0] NEXT_MASK     = 16'hFFFF;
    localparam logic [15:0] READ_ZERO     = 16'h0000;
    localparam logic        FLAG_RESET    = 1'h0;
    localparam logic        NP_ABLE_RESET = 1'h1;

    // selector codes
    localparam logic [4:0] SEL_IEEE_8023  = 5'h01;
    localparam logic [4:0] SEL_IEEE_8029  = 5'h02;
    localparam logic [4:0] SEL_RSVD_LOW   = 5'h00;
    localparam logic [4:0] SEL_RSVD_HIGH  = 5'h1F;

endpackage : anps_pkg

//--- verilog/anps_latch_flag.sv
`timescale 1ns/100ps
module anps_latch_flag #(
    parameter logic RESET_VALUE = 1'h0
) (
    // clock and reset
    input  wire logic i_clock,
    input  wire logic i_reset,
    // cause and clear
    input  wire logic i_set,
    input  wire logic i_clear,
    // flag
    output logic      o_flag
);

    logic flag_nxt;

    // set wins over a clear in the same cycle
    assign flag_nxt = i_set | (o_flag & ~i_clear);

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_flag <= RESET_VALUE;
        end else begin
            o_flag <= flag_nxt;
        end
    end

endmodule : anps_latch_flag

//--- verilog/anps_word_store.sv
`timescale 1ns/100ps
module anps_word_store #(
    parameter int                  WIDTH       = 16,
    parameter logic [WIDTH-1:0]    RESET_VALUE = '0,
    parameter logic [WIDTH-1:0]    MASK        = '1
) (
    // clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_reset,
    // load
    input  wire logic             i_load,
    input  wire logic [WIDTH-1:0] i_word,
    // held word
    output logic      [WIDTH-1:0] o_word
);

    logic [WIDTH-1:0] word_nxt;

    // masked bits always read zero
    assign word_nxt = i_load ? (i_word & MASK) : o_word;

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_word <= RESET_VALUE;
        end else begin
            o_word <= word_nxt;
        end
    end

endmodule : anps_word_store

//--- dv/anps_mgmt_model.sv
`timescale 1ns/100ps
module anps_mgmt_model (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_reset,
    // command from bench
    input  wire logic        i_go,
    input  wire logic        i_go_wr,
    input  wire logic [4:0]  i_go_addr,
    // register port
    output logic             o_reg_rd,
    output logic             o_reg_wr,
    output logic      [4:0]  o_reg_addr,
    input  wire logic [15:0] i_reg_rdata,
    input  wire logic        i_reg_rvalid,
    input  wire logic        i_reg_wack,
    // result
    output logic      [15:0] o_data,
    output logic             o_done
);
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_reg_rd   <= 1'h0;
            o_reg_wr   <= 1'h0;
            o_done     <= 1'h0;
            o_reg_addr <= 5'h00;
        end else begin
            o_reg_rd   <= i_go & ~i_go_wr;
            o_reg_wr   <= i_go & i_go_wr;
            // idle address wanders instead of holding
            o_reg_addr <= i_go ? i_go_addr : ~o_reg_addr;
            o_done     <= i_reg_rvalid | i_reg_wack;
            if (i_reg_rvalid) begin
                o_data <= i_reg_rdata;
            end
        end
    end
endmodule : anps_mgmt_model

//--- dv/anps_regs_sva.sv
`timescale 1ns/100ps
module anps_regs_sva #(
    parameter logic LOCAL_NP_ABLE = 1'h1
) (
    input wire logic        i_clock,
    input wire logic        i_reset,
    input wire logic        i_reg_rd,
    input wire logic        i_reg_wr,
    input wire logic [4:0]  i_reg_addr,
    input wire logic [15:0] o_reg_rdata,
    input wire logic        o_reg_rvalid,
    input wire logic        o_reg_wack,
    input wire logic        i_page_stored,
    input wire logic        i_page_is_base,
    input wire logic [15:0] i_page_word,
    input wire logic [15:0] o_partner_ability,
    input wire logic        o_page_received,
    input wire logic        o_selector_ieee_8023
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_reset);
    wire logic rd5 = i_reg_rd && i_reg_addr == 5'h05;
    wire logic rd6 = i_reg_rd && i_reg_addr == 5'h06;
    wire logic ld5 = i_page_stored && i_page_is_base;
    a_read_answer: assert property (
        i_reg_rd |=> o_reg_rvalid)
        else $error("read not answered");
    a_no_stray_valid: assert property (
        !i_reg_rd |=> !o_reg_rvalid)
        else $error("answer without read");
    a_write_ack: assert property (
        i_reg_wr && !i_reg_rd |=> o_reg_wack)
        else $error("write not acknowledged");
    a_unmapped_zero: assert property (
        i_reg_rd && !(i_reg_addr inside {5'h05, 5'h06, 5'h08})
        |=> o_reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_exp_fixed_bits: assert property (
        rd6 |=> o_reg_rdata[15:6] == 10'h000
        && o_reg_rdata[2] == LOCAL_NP_ABLE)
        else $error("expansion fixed bits wrong");
    a_ability_rsvd: assert property (
        rd5 |=> !o_reg_rdata[12])
        else $error("ability bit 12 set");
    a_page_sets_flag: assert property (
        i_page_stored |-> ##2 o_page_received)
        else $error("page received flag not set");
    // a page stored in the read cycle wins over the clear
    a_read_clears: assert property (
        rd6 && !i_page_stored |-> ##2 !o_page_received)
        else $error("page received not cleared by read");
    a_base_load: assert property (
        ld5 |-> ##2 o_partner_ability ==
        ($past(i_page_word, 2) & anps_pkg::ABILITY_MASK))
        else $error("ability word not loaded");
    a_sel_8023: assert property (
        ld5 |-> ##2 o_selector_ieee_8023
        == ($past(i_page_word[4:0], 2) == anps_pkg::SEL_IEEE_8023))
        else $error("selector flag wrong");
    c_base_load: cover property (ld5);
    c_next_load: cover property (i_page_stored && !i_page_is_base);
    c_exp_read: cover property (rd6 && o_page_received);
endmodule : anps_regs_sva

bind anps_regs anps_regs_sva #(.LOCAL_NP_ABLE(LOCAL_NP_ABLE)) u_sva (
    .i_clock, .i_reset, .i_reg_rd, .i_reg_wr, .i_reg_addr, .o_reg_rdata,
    .o_reg_rvalid, .o_reg_wack, .i_page_stored, .i_page_is_base,
    .i_page_word, .o_partner_ability, .o_page_received,
    .o_selector_ieee_8023);

//--- dv/tb_autoneg_partner_status_regs.sv
`timescale 1ns/100ps
module tb_autoneg_partner_status_regs;
    typedef struct {
        logic [15:0] w;
        logic [15:0] e5;
        logic [15:0] e6;
        logic        s;
    } anps_row_t;
    // only 00001 and 00010 selectors are sent
    anps_row_t rows [4] = '{
        '{16'hFFE1, 16'hEFE1, 16'h000F, 1'h1},
        '{16'h0002, 16'h0002, 16'h0007, 1'h0},
        '{16'h5421, 16'h4421, 16'h0007, 1'h1},
        '{16'hA3E2, 16'hA3E2, 16'h000F, 1'h0}
    };
    logic i_clock, i_reset, go, go_wr, done, rd, wr, rvalid, wack;
    logic stored, is_base, bpage, pfault, an_able, prx, txdis, alt;
    logic [4:0] go_addr, addr;
    logic [15:0] pword, rdata, mdata, d;
    logic prcv, s8023, srsvd;
    logic [15:0] pabl, pnext;
    int mismatches, samples_checked;

    initial begin
        i_clock = 1'h0;
        forever #5 i_clock = ~i_clock;
    end

    anps_mgmt_model u_mgmt (.i_clock(i_clock), .i_reset(i_reset), .i_go(go),
        .i_go_wr(go_wr), .i_go_addr(go_addr), .o_reg_rd(rd), .o_reg_wr(wr),
        .o_reg_addr(addr), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid),
        .i_reg_wack(wack), .o_data(mdata), .o_done(done));

    anps_regs dut_u (.i_clock(i_clock), .i_reset(i_reset), .i_reg_rd(rd),
        .i_reg_wr(wr), .i_reg_addr(addr), .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid), .o_reg_wack(wack), .i_page_stored(stored),
        .i_page_is_base(is_base), .i_page_word(pword), .i_base_page(bpage),
        .i_parallel_fault(pfault), .i_partner_an_able(an_able),
        .i_page_received_variable(prx), .i_transmit_disable(txdis),
        .i_alternate_next_page_feature(alt), .o_partner_ability(pabl),
        .o_partner_next_page(pnext), .o_page_received(prcv),
        .o_selector_ieee_8023(s8023), .o_selector_reserved(srsvd));

    task automatic summarize;
        $display("compares %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic access(input logic [4:0] a, input logic w);
        int n;
        @(posedge i_clock);
        go <= 1'h1;
        go_wr <= w;
        go_addr <= a;
        @(posedge i_clock);
        go <= 1'h0;
        for (n = 0; n < 8 && done !== 1'h1; n++) begin
            @(posedge i_clock);
            #1;
        end
        check(16'(done), 16'h0001);
        d = mdata;
    endtask : access

    task automatic page(input logic base, input logic [15:0] word);
        @(posedge i_clock);
        stored <= 1'h1;
        is_base <= base;
        pword <= word;
        @(posedge i_clock);
        stored <= 1'h0;
    endtask : page

    task automatic pulse(input logic b, input logic f, input logic t);
        @(posedge i_clock);
        {bpage, pfault, txdis} <= {b, f, t};
        @(posedge i_clock);
        {bpage, pfault, txdis} <= 3'h0;
    endtask : pulse

    initial begin
        {go, go_wr, stored, is_base, bpage, pfault, an_able, txdis, alt} = '0;
        {go_addr, pword} = '0;
        prx = 1'h1;
        i_reset = 1'h1;
        repeat (3) @(posedge i_clock);
        i_reset <= 1'h0;
        access(5'h05, 1'h0);
        check(d, 16'h0000);
        access(5'h06, 1'h0);
        check(d, 16'h0004);
        access(5'h08, 1'h0);
        check(d, 16'h0000);
        access(5'h1F, 1'h0);
        check(d, 16'h0000);
        @(posedge i_clock);
        an_able <= 1'h1;
        foreach (rows[i]) begin
            page(1'h1, rows[i].w);
            access(5'h05, 1'h1);
            access(5'h05, 1'h0);
            check(d, rows[i].e5);
            check(pabl, rows[i].e5);
            check(16'(s8023), 16'(rows[i].s));
            check(16'(srsvd), 16'h0000);
            access(5'h06, 1'h0);
            check(d, rows[i].e6);
            access(5'h06, 1'h0);
            check(d, rows[i].e6 & 16'hFFFD);
        end
        page(1'h0, 16'h2ABC);
        access(5'h08, 1'h0);
        check(d, 16'h2ABC);
        check(pnext, 16'h2ABC);
        access(5'h05, 1'h0);
        check(d, 16'hA3E2);
        check(16'(prcv), 16'h0001);
        page(1'h1, 16'h0001);
        pulse(1'h1, 1'h0, 1'h1);
        access(5'h06, 1'h0);
        check(d, 16'h0007);
        @(posedge i_clock);
        alt <= 1'h1;
        page(1'h1, 16'h8001);
        pulse(1'h1, 1'h1, 1'h0);
        pulse(1'h0, 1'h0, 1'h1);
        access(5'h06, 1'h0);
        check(d, 16'h003D);
        check(16'(prcv), 16'h0000);
        access(5'h06, 1'h0);
        check(d, 16'h000D);
        check(16'(s8023), 16'h0001);
        // mid-run reset drops all captured state
        @(posedge i_clock);
        i_reset <= 1'h1;
        repeat (3) @(posedge i_clock);
        i_reset <= 1'h0;
        access(5'h05, 1'h0);
        check(d, 16'h0000);
        check(pabl, 16'h0000);
        access(5'h08, 1'h0);
        check(d, 16'h0000);
        access(5'h06, 1'h0);
        check(d, 16'h0005);
        summarize();
    end

    initial begin
        #100us;
        mismatches++;
        summarize();
    end
endmodule : tb_autoneg_partner_status_regs
